// ===== hdl/ucrd_byte_ser.v
`timescale 1ns/1ps

// ----------------------------------------
// Word to byte serializer, low byte first
// ----------------------------------------
module ucrd_byte_ser
(
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        load_i,
	input  wire [31:0] word_i,
	input  wire [2:0]  count_i,
	input  wire        ready_i,
	output wire [7:0]  byte_o,
	output wire        valid_o,
	output wire        idle_o
);

	reg [31:0] data_r;
	reg [2:0]  left_r;
	reg        valid_r;

	assign byte_o  = data_r[7:0];
	assign valid_o = valid_r;
	assign idle_o  = ~valid_r;

	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_r  <= 32'h0000_0000;
			left_r  <= 3'h0;
			valid_r <= 1'b0;
		end
		else if (load_i)
		begin
			data_r  <= word_i;
			left_r  <= count_i;
			valid_r <= (count_i != 3'h0);
		end
		else if (valid_r && ready_i)
		begin
			data_r  <= {8'h00, data_r[31:8]};
			left_r  <= left_r - 3'h1;
			valid_r <= (left_r > 3'h1);
		end
	end

endmodule // ucrd_byte_ser

// ===== hdl/ucrd_ctrl_decoder.v
// Overview of operation
// - Serve device, config, string, qualifier, other-speed descriptors
// - Stall interface and endpoint descriptor requests
// - Device status: bit1 remote wakeup, bit0 self-powered
// - Endpoint status from index 81h/02h/83h, halt bit0
// - Set feature: halt, remote wakeup, test mode
// - Feature value 00h halt, 01h wakeup, 02h test
// - Halt targets indexed endpoint; wakeup needs index zero, test mode index low byte zero
// - Set configuration enters configured state
// - Set interface acks only alternate and interface zero
// - Vendor requests reach system and MAC registers
// - MAC register access stalled in normal state
// - Register write: one 32-bit word, length four
// - Register read: single register, length four
// - Register read returns four bytes of data
// - Statistics request returns whole selected set
// - Snapshot counters, never clear them afterwards
// - Statistics index 0 RX 28h, 1 TX 30h
// - Clear feature removes halt or remote wakeup
`timescale 1ns/1ps
`include "ucrd_defs.vh"

module ucrd_ctrl_decoder
#(
	parameter NUM_EP = 3
)
(
	input  wire              sys_clk_i,
	input  wire              rst_i,
	input  wire              setup_valid_i,
	input  wire [7:0]        setup_type_i,
	input  wire [7:0]        setup_req_i,
	input  wire [15:0]       setup_value_i,
	input  wire [15:0]       setup_index_i,
	input  wire [15:0]       setup_length_i,
	input  wire [7:0]        rx_byte_i,
	input  wire              rx_valid_i,
	input  wire              tx_ready_i,
	input  wire              self_powered_i,
	input  wire              normal_state_i,
	input  wire [31:0]       csr_rdata_i,
	input  wire              csr_done_i,
	input  wire [31:0]       stat_data_i,
	input  wire              stat_valid_i,
	output wire [7:0]        tx_byte_o,
	output wire              tx_valid_o,
	output reg               ack_o,
	output reg               stall_o,
	output reg               desc_req_o,
	output reg  [7:0]        desc_type_o,
	output reg  [7:0]        desc_index_o,
	output reg  [15:0]       desc_lang_o,
	output reg  [15:0]       desc_length_o,
	output reg  [6:0]        dev_addr_o,
	output reg               configured_o,
	output reg               remote_wake_en_o,
	output reg               test_mode_o,
	output reg  [7:0]        test_sel_o,
	output reg  [NUM_EP-1:0] ep_halt_o,
	output reg  [11:0]       csr_addr_o,
	output reg  [31:0]       csr_wdata_o,
	output reg               csr_wr_o,
	output reg               csr_rd_o,
	output reg               csr_mac_o,
	output reg               stat_snap_o,
	output reg               stat_sel_tx_o,
	output reg  [3:0]        stat_word_o,
	output reg               stat_rd_o
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_EXEC = 7'h02;
	localparam [6:0] S_SEND = 7'h04;
	localparam [6:0] S_RECV = 7'h08;
	localparam [6:0] S_CSR  = 7'h10;
	localparam [6:0] S_STAT = 7'h20;
	localparam [6:0] S_FIN  = 7'h40;

	// ----------------------------------------
	// Endpoint number from index, zero if unsupported
	// ----------------------------------------
	function [1:0] ep_num;
		input [15:0] idx;
		input        full_addr;
		begin
			ep_num = 2'h0;
			if (full_addr)
			begin
				if (idx == {8'h00, `UCRD_EP_BULK_IN})
					ep_num = 2'h1;
				else if (idx == {8'h00, `UCRD_EP_BULK_OUT})
					ep_num = 2'h2;
				else if (idx == {8'h00, `UCRD_EP_INTR_IN})
					ep_num = 2'h3;
			end
			else if (idx[15:4] == 12'h000 && idx[3:0] != 4'h0 && idx[3:0] <= 4'h3)
				ep_num = idx[1:0];
		end
	endfunction

	reg [6:0]  state_r;
	reg [7:0]  type_r;
	reg [7:0]  req_r;
	reg [15:0] value_r;
	reg [15:0] index_r;
	reg [15:0] length_r;
	reg [1:0]  byte_cnt_r;
	reg        is_read_r;
	reg        is_stat_r;
	reg        is_addr_r;
	reg        ser_load_r;
	reg [31:0] ser_word_r;
	reg [2:0]  ser_count_r;
	reg [3:0]  stat_last_r;

	wire       ser_idle;
	wire [1:0] ep_status = ep_num(index_r, 1'b1);
	wire [1:0] ep_feat   = ep_num(index_r, 1'b0);
	wire       mac_addr  = (index_r[11:0] >= `UCRD_MAC_BASE);
	wire       mac_block = mac_addr && normal_state_i;
	wire       in_exec   = (state_r == S_EXEC);
	wire       halt_req  = in_exec && (type_r == `UCRD_RT_STD_OUT_EP) && (value_r == `UCRD_FT_EP_HALT)
	                       && (ep_feat != 2'h0);
	wire       halt_set  = halt_req && (req_r == `UCRD_RQ_SET_FEATURE);
	wire       halt_clr  = halt_req && (req_r == `UCRD_RQ_CLR_FEATURE);

	// ----------------------------------------
	// Data stage serializer
	// ----------------------------------------
	ucrd_byte_ser u_ser
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.load_i    (ser_load_r),
		.word_i    (ser_word_r),
		.count_i   (ser_count_r),
		.ready_i   (tx_ready_i),
		.byte_o    (tx_byte_o),
		.valid_o   (tx_valid_o),
		.idle_o    (ser_idle)
	);

	// ----------------------------------------
	// Endpoint halt flags
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g = g + 1)
		begin : g_halt
			always @(posedge sys_clk_i or posedge rst_i)
			begin
				if (rst_i)
					ep_halt_o[g] <= 1'b0;
				else if (halt_set && ep_feat == g + 1)
					ep_halt_o[g] <= 1'b1;
				else if (halt_clr && ep_feat == g + 1)
					ep_halt_o[g] <= 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Request sequencer
	// ----------------------------------------
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r          <= S_IDLE;
			type_r           <= 8'h00;
			req_r            <= 8'h00;
			value_r          <= 16'h0000;
			index_r          <= 16'h0000;
			length_r         <= 16'h0000;
			byte_cnt_r       <= 2'h0;
			is_read_r        <= 1'b0;
			is_stat_r        <= 1'b0;
			is_addr_r        <= 1'b0;
			ser_load_r       <= 1'b0;
			ser_word_r       <= 32'h0000_0000;
			ser_count_r      <= 3'h0;
			stat_last_r      <= 4'h0;
			ack_o            <= 1'b0;
			stall_o          <= 1'b0;
			desc_req_o       <= 1'b0;
			desc_type_o      <= 8'h00;
			desc_index_o     <= 8'h00;
			desc_lang_o      <= 16'h0000;
			desc_length_o    <= 16'h0000;
			dev_addr_o       <= 7'h00;
			configured_o     <= 1'b0;
			remote_wake_en_o <= 1'b0;
			test_mode_o      <= 1'b0;
			test_sel_o       <= 8'h00;
			csr_addr_o       <= 12'h000;
			csr_wdata_o      <= 32'h0000_0000;
			csr_wr_o         <= 1'b0;
			csr_rd_o         <= 1'b0;
			csr_mac_o        <= 1'b0;
			stat_snap_o      <= 1'b0;
			stat_sel_tx_o    <= 1'b0;
			stat_word_o      <= 4'h0;
			stat_rd_o        <= 1'b0;
		end
		else
		begin
			// Strobes last one cycle
			ack_o       <= 1'b0;
			stall_o     <= 1'b0;
			desc_req_o  <= 1'b0;
			csr_wr_o    <= 1'b0;
			csr_rd_o    <= 1'b0;
			stat_snap_o <= 1'b0;
			stat_rd_o   <= 1'b0;
			ser_load_r  <= 1'b0;
			case (state_r)
			S_IDLE:
			begin
				if (setup_valid_i)
				begin
					type_r    <= setup_type_i;
					req_r     <= setup_req_i;
					value_r   <= setup_value_i;
					index_r   <= setup_index_i;
					length_r  <= setup_length_i;
					is_read_r <= 1'b0;
					is_stat_r <= 1'b0;
					is_addr_r <= 1'b0;
					state_r   <= S_EXEC;
				end
			end
			S_EXEC:
			begin
				state_r <= S_IDLE;
				stall_o <= 1'b1;
				if (type_r == `UCRD_RT_STD_IN_DEV && req_r == `UCRD_RQ_GET_DESC)
				begin
					// Contents come from the descriptor engine; only routing here
					if (value_r[15:8] == `UCRD_DT_DEVICE || value_r[15:8] == `UCRD_DT_CONFIG
						|| value_r[15:8] == `UCRD_DT_STRING || value_r[15:8] == `UCRD_DT_QUALIFIER
						|| value_r[15:8] == `UCRD_DT_OTHER_SPEED)
					begin
						stall_o       <= 1'b0;
						desc_req_o    <= 1'b1;
						desc_type_o   <= value_r[15:8];
						desc_index_o  <= value_r[7:0];
						desc_lang_o   <= index_r;
						desc_length_o <= length_r;
					end
					// Interface and endpoint types fall through to stall
				end
				else if (type_r == `UCRD_RT_STD_IN_DEV && req_r == `UCRD_RQ_GET_CONFIG)
				begin
					stall_o     <= 1'b0;
					ser_word_r  <= {31'h0000_0000, configured_o};
					ser_count_r <= 3'h1;
					ser_load_r  <= 1'b1;
					state_r     <= S_SEND;
				end
				else if (type_r == `UCRD_RT_STD_IN_IFC && req_r == `UCRD_RQ_GET_IFC)
				begin
					stall_o     <= 1'b0;
					ser_word_r  <= 32'h0000_0000;
					ser_count_r <= 3'h1;
					ser_load_r  <= 1'b1;
					state_r     <= S_SEND;
				end
				else if (type_r == `UCRD_RT_STD_IN_DEV && req_r == `UCRD_RQ_GET_STATUS)
				begin
					stall_o     <= 1'b0;
					ser_word_r  <= {30'h0000_0000, remote_wake_en_o, self_powered_i};
					ser_count_r <= 3'h2;
					ser_load_r  <= 1'b1;
					state_r     <= S_SEND;
				end
				else if (type_r == `UCRD_RT_STD_IN_EP && req_r == `UCRD_RQ_GET_STATUS && ep_status != 2'h0)
				begin
					stall_o     <= 1'b0;
					ser_word_r  <= {31'h0000_0000, ep_halt_o[ep_status - 2'h1]};
					ser_count_r <= 3'h2;
					ser_load_r  <= 1'b1;
					state_r     <= S_SEND;
				end
				else if (type_r == `UCRD_RT_STD_OUT_DEV && req_r == `UCRD_RQ_SET_ADDRESS)
				begin
					// New address applies only once the status stage is acked
					stall_o   <= 1'b0;
					is_addr_r <= 1'b1;
					state_r   <= S_FIN;
				end
				else if (req_r == `UCRD_RQ_SET_FEATURE || req_r == `UCRD_RQ_CLR_FEATURE)
				begin
					if (halt_req)
					begin
						stall_o <= 1'b0;
						state_r <= S_FIN;
					end
					else if (type_r == `UCRD_RT_STD_OUT_DEV && value_r == `UCRD_FT_REMOTE_WAKE
						&& index_r == 16'h0000)
					begin
						stall_o          <= 1'b0;
						remote_wake_en_o <= (req_r == `UCRD_RQ_SET_FEATURE);
						state_r          <= S_FIN;
					end
					else if (type_r == `UCRD_RT_STD_OUT_DEV && req_r == `UCRD_RQ_SET_FEATURE
						&& value_r == {8'h00, `UCRD_FT_TEST_MODE} && index_r[7:0] == 8'h00)
					begin
						stall_o     <= 1'b0;
						test_mode_o <= 1'b1;
						test_sel_o  <= index_r[15:8];
						state_r     <= S_FIN;
					end
				end
				else if (type_r == `UCRD_RT_STD_OUT_DEV && req_r == `UCRD_RQ_SET_CONFIG)
				begin
					// Value zero returns to the addressed state
					if (value_r == `UCRD_CONFIG_VALUE || value_r == 16'h0000)
					begin
						stall_o      <= 1'b0;
						configured_o <= (value_r == `UCRD_CONFIG_VALUE);
						state_r      <= S_FIN;
					end
				end
				else if (type_r == `UCRD_RT_STD_OUT_IFC && req_r == `UCRD_RQ_SET_IFC)
				begin
					if (value_r == 16'h0000 && index_r == 16'h0000)
					begin
						stall_o <= 1'b0;
						state_r <= S_FIN;
					end
				end
				else if (type_r == `UCRD_RT_VND_OUT && req_r == `UCRD_RQ_REG_WRITE)
				begin
					// Bursts have no path: length must be one word
					if (!mac_block && length_r == `UCRD_REG_LENGTH && index_r[15:12] == 4'h0)
					begin
						stall_o    <= 1'b0;
						csr_addr_o <= index_r[11:0];
						csr_mac_o  <= mac_addr;
						byte_cnt_r <= 2'h0;
						state_r    <= S_RECV;
					end
				end
				else if (type_r == `UCRD_RT_VND_IN && req_r == `UCRD_RQ_REG_READ)
				begin
					if (!mac_block && length_r == `UCRD_REG_LENGTH && index_r[15:12] == 4'h0)
					begin
						stall_o    <= 1'b0;
						csr_addr_o <= index_r[11:0];
						csr_mac_o  <= mac_addr;
						csr_rd_o   <= 1'b1;
						is_read_r  <= 1'b1;
						state_r    <= S_CSR;
					end
				end
				else if (type_r == `UCRD_RT_VND_IN && req_r == `UCRD_RQ_GET_STATS)
				begin
					if (index_r[15:1] == 15'h0000)
					begin
						stall_o       <= 1'b0;
						is_stat_r     <= 1'b1;
						stat_snap_o   <= 1'b1;
						stat_sel_tx_o <= index_r[0];
						stat_last_r   <= index_r[0] ? `UCRD_STAT_TX_LAST : `UCRD_STAT_RX_LAST;
						stat_word_o   <= 4'h0;
						stat_rd_o     <= 1'b1;
						state_r       <= S_STAT;
					end
				end
			end
			S_RECV:
			begin
				if (rx_valid_i)
				begin
					csr_wdata_o <= {rx_byte_i, csr_wdata_o[31:8]};
					byte_cnt_r  <= byte_cnt_r + 2'h1;
					if (byte_cnt_r == 2'h3)
					begin
						csr_wr_o <= 1'b1;
						state_r  <= S_CSR;
					end
				end
			end
			S_CSR:
			begin
				if (csr_done_i)
				begin
					if (is_read_r)
					begin
						ser_word_r  <= csr_rdata_i;
						ser_count_r <= 3'h4;
						ser_load_r  <= 1'b1;
						state_r     <= S_SEND;
					end
					else
						state_r <= S_FIN;
				end
			end
			S_STAT:
			begin
				if (stat_valid_i)
				begin
					ser_word_r  <= stat_data_i;
					ser_count_r <= 3'h4;
					ser_load_r  <= 1'b1;
					state_r     <= S_SEND;
				end
			end
			S_SEND:
			begin
				// Skip the load cycle; serializer is not yet busy then
				if (!ser_load_r && ser_idle)
				begin
					if (is_stat_r && stat_word_o != stat_last_r)
					begin
						stat_word_o <= stat_word_o + 4'h1;
						stat_rd_o   <= 1'b1;
						state_r     <= S_STAT;
					end
					else
						state_r <= S_FIN;
				end
			end
			S_FIN:
			begin
				ack_o   <= 1'b1;
				state_r <= S_IDLE;
				if (is_addr_r)
					dev_addr_o <= value_r[6:0];
			end
			default:
			begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end

endmodule // ucrd_ctrl_decoder

// ===== hdl/ucrd_defs.vh
`ifndef UCRD_DEFS_VH
`define UCRD_DEFS_VH

// ----------------------------------------
// Request types
// ----------------------------------------
`define UCRD_RT_STD_OUT_DEV  8'h00
`define UCRD_RT_STD_OUT_IFC  8'h01
`define UCRD_RT_STD_OUT_EP   8'h02
`define UCRD_RT_STD_IN_DEV   8'h80
`define UCRD_RT_STD_IN_IFC   8'h81
`define UCRD_RT_STD_IN_EP    8'h82
`define UCRD_RT_VND_OUT      8'h40
`define UCRD_RT_VND_IN       8'hC0

// ----------------------------------------
// Request codes
// ----------------------------------------
`define UCRD_RQ_GET_STATUS   8'h00
`define UCRD_RQ_CLR_FEATURE  8'h01
`define UCRD_RQ_SET_FEATURE  8'h03
`define UCRD_RQ_SET_ADDRESS  8'h05
`define UCRD_RQ_GET_DESC     8'h06
`define UCRD_RQ_GET_CONFIG   8'h08
`define UCRD_RQ_SET_CONFIG   8'h09
`define UCRD_RQ_GET_IFC      8'h0A
`define UCRD_RQ_SET_IFC      8'h0B
`define UCRD_RQ_REG_WRITE    8'hA0
`define UCRD_RQ_REG_READ     8'hA1
`define UCRD_RQ_GET_STATS    8'hA2

// ----------------------------------------
// Descriptor types
// ----------------------------------------
`define UCRD_DT_DEVICE       8'h01
`define UCRD_DT_CONFIG       8'h02
`define UCRD_DT_STRING       8'h03
`define UCRD_DT_INTERFACE    8'h04
`define UCRD_DT_ENDPOINT     8'h05
`define UCRD_DT_QUALIFIER    8'h06
`define UCRD_DT_OTHER_SPEED  8'h07

// ----------------------------------------
// Feature selectors and values
// ----------------------------------------
`define UCRD_FT_EP_HALT      16'h0000
`define UCRD_FT_REMOTE_WAKE  16'h0001
`define UCRD_FT_TEST_MODE    8'h02
`define UCRD_CONFIG_VALUE    16'h0001
`define UCRD_REG_LENGTH      16'h0004

// ----------------------------------------
// Endpoint addresses seen in the index field
// ----------------------------------------
`define UCRD_EP_BULK_IN      8'h81
`define UCRD_EP_BULK_OUT     8'h02
`define UCRD_EP_INTR_IN      8'h83

// ----------------------------------------
// Register space and statistics
// ----------------------------------------
`define UCRD_MAC_BASE        12'h100
`define UCRD_STAT_RX_LEN     16'h0028
`define UCRD_STAT_TX_LEN     16'h0030
`define UCRD_STAT_RX_LAST    4'h9
`define UCRD_STAT_TX_LAST    4'hB

`endif

// ===== verification/ucrd_ctrl_decoder_chk.sv
`timescale 1ns/1ps
module ucrd_ctrl_decoder_chk
#(
	parameter NUM_EP = 3
)
(
	input wire              sys_clk_i,
	input wire              rst_i,
	input wire              setup_valid_i,
	input wire [7:0]        setup_type_i,
	input wire [7:0]        setup_req_i,
	input wire [15:0]       setup_value_i,
	input wire [15:0]       setup_index_i,
	input wire              rx_valid_i,
	input wire              normal_state_i,
	input wire              ack_o,
	input wire              stall_o,
	input wire              desc_req_o,
	input wire              configured_o,
	input wire [NUM_EP-1:0] ep_halt_o,
	input wire              csr_wr_o,
	input wire              stat_snap_o,
	input wire              stat_rd_o,
	input wire              stat_sel_tx_o,
	input wire [3:0]        stat_word_o
);
	// ----------------------------------------
	// Request tracking
	// ----------------------------------------
	reg         busy_r;
	reg  [2:0]  rx_cnt_r;
	wire        hs   = ack_o | stall_o | desc_req_o;
	wire        take = setup_valid_i & (~busy_r | hs);
	wire [15:0] rq   = {setup_type_i, setup_req_i};
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_r   <= 1'b0;
			rx_cnt_r <= 3'h0;
		end
		else
		begin
			busy_r   <= take | (busy_r & ~hs);
			rx_cnt_r <= take ? 3'h0 : rx_cnt_r + {2'h0, rx_valid_i};
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_cfg_done;
		configured_o ##1 ack_o;
	endsequence
	sequence s_halt_done;
		ep_halt_o[0] ##1 ack_o;
	endsequence
	property p_desc_ok;
		take && rq == 16'h8006 && setup_value_i[15:8] inside {8'h01, 8'h02, 8'h03, 8'h06, 8'h07}
			|-> ##[2:3] desc_req_o;
	endproperty
	a_desc_ok: assert property (p_desc_ok) else $error("descriptor not forwarded");
	property p_desc_stall;
		take && rq == 16'h8006 && setup_value_i[15:8] inside {8'h04, 8'h05} |-> ##[2:3] stall_o && !desc_req_o;
	endproperty
	a_desc_stall: assert property (p_desc_stall) else $error("descriptor not stalled");
	property p_ifc_ack;
		take && rq == 16'h010B && setup_value_i == 16'h0000 && setup_index_i == 16'h0000 |-> ##[3:4] ack_o;
	endproperty
	a_ifc_ack: assert property (p_ifc_ack) else $error("interface zero not acked");
	property p_ifc_stall;
		take && rq == 16'h010B && (setup_value_i | setup_index_i) != 16'h0000 |-> ##[2:3] stall_o;
	endproperty
	a_ifc_stall: assert property (p_ifc_stall) else $error("bad interface not stalled");
	property p_cfg;
		take && rq == 16'h0009 && setup_value_i == 16'h0001 |-> ##[2:3] s_cfg_done;
	endproperty
	a_cfg: assert property (p_cfg) else $error("configuration not entered");
	property p_mac;
		take && normal_state_i && (rq == 16'h40A0 || rq == 16'hC0A1) && setup_index_i[11:0] >= 12'h100
			|-> ##[2:3] stall_o;
	endproperty
	a_mac: assert property (p_mac) else $error("MAC access not stalled");
	property p_wr;
		csr_wr_o |-> rx_cnt_r == 3'h4;
	endproperty
	a_wr: assert property (p_wr) else $error("write without four bytes");
	property p_halt;
		take && rq == 16'h0203 && setup_value_i == 16'h0000 && setup_index_i == 16'h0001 |-> ##[2:3] s_halt_done;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not set");
	property p_stat_word;
		stat_rd_o |-> stat_word_o <= (stat_sel_tx_o ? 4'hB : 4'h9);
	endproperty
	a_stat_word: assert property (p_stat_word) else $error("statistics word out of range");
	property p_snap;
		stat_snap_o |-> stat_rd_o && stat_word_o == 4'h0;
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot not at first word");
endmodule // ucrd_ctrl_decoder_chk

// ===== verification/ucrd_ctrl_decoder_tb.sv
`timescale 1ns/1ps
module ucrd_ctrl_decoder_tb;
	localparam [2:0] ACK = 3'h1, STL = 3'h2, DSC = 3'h4;
	logic        sys_clk_i, rst_i, self_powered_i, normal_state_i, csr_done_i, stat_valid_i, slow, em;
	logic [31:0] csr_rdata_i, stat_data_i, wd, rnd, seed;
	logic [11:0] ea;
	wire         setup_valid_i, rx_valid_i, tx_ready_i, tx_valid_o, ack_o, stall_o, desc_req_o, configured_o;
	wire         remote_wake_en_o, test_mode_o, csr_wr_o, csr_rd_o, csr_mac_o, stat_snap_o, stat_sel_tx_o, stat_rd_o;
	wire [7:0]   setup_type_i, setup_req_i, rx_byte_i, tx_byte_o, desc_type_o, desc_index_o, test_sel_o;
	wire [15:0]  setup_value_i, setup_index_i, setup_length_i, desc_lang_o, desc_length_o;
	wire [6:0]   dev_addr_o;
	wire [2:0]   ep_halt_o;
	wire [11:0]  csr_addr_o;
	wire [31:0]  csr_wdata_o;
	wire [3:0]   stat_word_o;
	logic [7:0]  exp_b [$];
	logic [2:0]  exp_h [$];
	logic [15:0] epi [3] = '{16'h0081, 16'h0002, 16'h0083};
	int          num_errors = 0, total_checks = 0, snaps, k, j;

	ucrd_ctrl_decoder #(.NUM_EP(3)) dut (.*);
	ucrd_host_model host (.sys_clk_i(sys_clk_i), .slow_i(slow), .rnd_i(rnd), .hs_i(ack_o | stall_o | desc_req_o),
		.setup_valid_o(setup_valid_i), .type_o(setup_type_i), .req_o(setup_req_i), .value_o(setup_value_i),
		.index_o(setup_index_i), .length_o(setup_length_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
		.tx_ready_o(tx_ready_i));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] sw(input logic sel, input logic [3:0] w);
		return {w, 4'hC, sel ? 8'hE1 : 8'h3D, w, 4'h7, 8'h96};
	endfunction
	task chk_v(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chk_b(input logic [7:0] g);
		chk_v({24'h0, g}, exp_b.size() ? {24'h0, exp_b.pop_front()} : 32'hFFFFFFFF);
	endtask
	task chk_h(input logic [2:0] g);
		chk_v({29'h0, g}, exp_h.size() ? {29'h0, exp_h.pop_front()} : 32'hFFFFFFFF);
	endtask
	task eb(input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++)
			exp_b.push_back(w[8*i +: 8]);
	endtask
	task rq(input [7:0] t, input [7:0] r, input [15:0] v, input [15:0] i, input [15:0] l, input [2:0] h);
		exp_h.push_back(h);
		host.xfer(t, r, v, i, l, wd);
		@(negedge sys_clk_i);
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, monitor, near side, watchdog
	// ----------------------------------------
	initial
	begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(negedge sys_clk_i)
		rnd <= xs();
	always @(posedge sys_clk_i)
	begin
		if (!rst_i && tx_valid_o && tx_ready_i)
			chk_b(tx_byte_o);
		if (!rst_i && (ack_o | stall_o | desc_req_o))
			chk_h({desc_req_o, stall_o, ack_o});
	end
	initial
	begin : near_side
		logic       sel;
		logic [3:0] w;
		forever
		begin
			@(posedge sys_clk_i);
			if (csr_wr_o | csr_rd_o)
			begin
				if (csr_wr_o)
					chk_v(csr_wdata_o, wd);
				chk_v({csr_mac_o, csr_addr_o}, {em, ea});
				repeat (2) @(negedge sys_clk_i);
				csr_rdata_i = wd;
				csr_done_i  = 1'b1;
				@(negedge sys_clk_i);
				csr_done_i  = 1'b0;
				csr_rdata_i = ~wd;
			end
			if (stat_rd_o)
			begin
				snaps += stat_snap_o;
				sel = stat_sel_tx_o;
				w   = stat_word_o;
				@(negedge sys_clk_i);
				stat_data_i  = sw(sel, w);
				stat_valid_i = 1'b1;
				@(negedge sys_clk_i);
				stat_valid_i = 1'b0;
				stat_data_i  = ~stat_data_i;
			end
		end
	end
	// Whole run is several hundred cycles; allow far more
	initial
	begin
		#2000000;
		num_errors++;
		results;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_i, self_powered_i, normal_state_i, csr_done_i, stat_valid_i, slow, em} = 7'h40;
		{csr_rdata_i, stat_data_i, wd, rnd, ea} = 140'h0;
		seed = 32'hD787;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 1'b0;
		eb(0, 1); rq(8'h80, 8'h08, 0, 0, 1, ACK);
		rq(8'h00, 8'h09, 16'h0002, 0, 0, STL);
		rq(8'h00, 8'h09, 16'h0001, 0, 0, ACK);
		chk_v(configured_o, 1);
		eb(1, 1); rq(8'h80, 8'h08, 0, 0, 1, ACK);
		slow = 1'b1;
		eb(0, 1); rq(8'h81, 8'h0A, 0, 0, 1, ACK);
		for (k = 0; k < 3; k++)
			rq(8'h01, 8'h0B, 16'(k % 2), 16'(k / 2), 0, k ? STL : ACK);
		for (k = 1; k < 8; k++)
		begin
			rq(8'h80, 8'h06, {8'(k), 8'(k)}, 16'h0409, 16'h0012, (k == 4 || k == 5) ? STL : DSC);
			if (k != 4 && k != 5)
			begin
				chk_v({desc_type_o, desc_lang_o}, {8'(k), 16'h0409});
				chk_v({desc_index_o, desc_length_o}, {8'(k), 16'h0012});
			end
		end
		self_powered_i = 1'b1;
		eb(1, 2); rq(8'h80, 8'h00, 0, 0, 2, ACK);
		rq(8'h00, 8'h03, 16'h0001, 0, 0, ACK);
		eb(3, 2); rq(8'h80, 8'h00, 0, 0, 2, ACK);
		rq(8'h00, 8'h01, 16'h0001, 0, 0, ACK);
		chk_v(remote_wake_en_o, 0);
		for (k = 0; k < 3; k++)
		begin
			rq(8'h02, 8'h03, 0, 16'(k + 1), 0, ACK);
			chk_v(ep_halt_o, 32'(1 << k));
			eb(1, 2); rq(8'h82, 8'h00, 0, epi[k], 2, ACK);
			rq(8'h02, 8'h01, 0, 16'(k + 1), 0, ACK);
			eb(0, 2); rq(8'h82, 8'h00, 0, epi[k], 2, ACK);
		end
		rq(8'h82, 8'h00, 0, 16'h0084, 2, STL);
		slow = 1'b0;
		wd = xs(); ea = 12'h023; rq(8'h40, 8'hA0, 0, 16'h0023, 4, ACK);
		wd = xs(); ea = 12'h104; em = 1'b1; rq(8'h40, 8'hA0, 0, 16'h0104, 4, ACK);
		normal_state_i = 1'b1;
		rq(8'h40, 8'hA0, 0, 16'h0104, 4, STL);
		rq(8'hC0, 8'hA1, 0, 16'h01F0, 4, STL);
		rq(8'h40, 8'hA0, 0, 16'h0020, 8, STL);
		slow = 1'b1;
		wd = xs(); ea = 12'h0AC; em = 1'b0; eb(wd, 4); rq(8'hC0, 8'hA1, 0, 16'h00AC, 4, ACK);
		rq(8'hC0, 8'hA1, 0, 16'h10AC, 4, STL);
		for (k = 0; k < 3; k++)
		begin
			snaps = 0;
			for (j = 0; k < 2 && j < (k ? 12 : 10); j++)
				eb(sw(k[0], j[3:0]), 4);
			rq(8'hC0, 8'hA2, 0, 16'(k), k ? 16'h0030 : 16'h0028, k < 2 ? ACK : STL);
			chk_v(32'(snaps), 32'(k < 2));
		end
		rq(8'h00, 8'h05, 16'h002A, 0, 0, ACK);
		chk_v(dev_addr_o, 32'h2A);
		rq(8'h00, 8'h03, 16'h0002, 16'h0400, 0, ACK);
		chk_v({test_mode_o, test_sel_o}, 32'h104);
		rq(8'h00, 8'h09, 0, 0, 0, ACK);
		chk_v(configured_o, 0);
		chk_v(exp_b.size() + exp_h.size(), 0);
		results;
	end
endmodule // ucrd_ctrl_decoder_tb

bind ucrd_ctrl_decoder ucrd_ctrl_decoder_chk #(.NUM_EP(NUM_EP)) u_chk (.*);

// ===== verification/ucrd_host_model.sv
`timescale 1ns/1ps
module ucrd_host_model
(
	input  wire        sys_clk_i,
	input  wire        slow_i,
	input  wire [31:0] rnd_i,
	input  wire        hs_i,
	output reg         setup_valid_o,
	output reg  [7:0]  type_o,
	output reg  [7:0]  req_o,
	output reg  [15:0] value_o,
	output reg  [15:0] index_o,
	output reg  [15:0] length_o,
	output reg  [7:0]  rx_byte_o,
	output reg         rx_valid_o,
	output reg         tx_ready_o
);
	initial
	begin
		{setup_valid_o, type_o, req_o, value_o, index_o, length_o} = 65'h0;
		{rx_byte_o, rx_valid_o, tx_ready_o} = 10'h0;
	end
	// Slow host stalls the data stage at random
	always @(negedge sys_clk_i)
		tx_ready_o <= ~slow_i | rnd_i[3];
	// ----------------------------------------
	// One control transfer
	// ----------------------------------------
	task automatic xfer(input [7:0] t, input [7:0] r, input [15:0] v, input [15:0] i, input [15:0] l,
		input [31:0] wd);
		integer n;
		integer j;
		begin
			@(negedge sys_clk_i);
			{type_o, req_o, value_o, index_o, length_o} = {t, r, v, i, l};
			setup_valid_o = 1'b1;
			@(negedge sys_clk_i);
			setup_valid_o = 1'b0;
			// Fields are stale now, so show garbage
			{type_o, req_o, value_o, index_o, length_o} = ~{t, r, v, i, l};
			n = 0;
			while (n < 400 && !hs_i)
			begin
				@(negedge sys_clk_i);
				n = n + 1;
				if (n == 2 && t == 8'h40 && !hs_i)
				begin
					for (j = 0; j < 4; j = j + 1)
					begin
						rx_byte_o  = wd[8*j +: 8];
						rx_valid_o = 1'b1;
						@(negedge sys_clk_i);
						rx_valid_o = 1'b0;
						rx_byte_o  = ~wd[8*j +: 8];
					end
				end
			end
		end
	endtask
endmodule // ucrd_host_model
